// [design/ccr_core_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.vh"

// ==========================================================
// Overview
// This block holds the state that the program can see: the
// accumulator, two pointer registers, two short-direct registers,
// the program counter, three carry/zero pairs and the return stack.
// The instruction decoder drives every strobe and operand; the
// internal data-space bus reaches the five mapped byte registers.
//
// Timing
// Every strobe is sampled at the rising clock edge and takes effect
// at that same edge. The read path is combinational, so a read in
// one cycle sees the value that the last edge stored.
//
// Stack hazards
// A push moves every level one deeper and drops the deepest one.
// The depth counter saturates, so after more than six calls the
// oldest return address is gone and cannot be told apart from a
// valid one. Software must keep the nesting within six levels.
// A return at depth zero does not shift the levels and the program
// counter simply steps on to the next instruction.
// A push and a pop in one cycle count as a push for the stack levels and
// depth, while the program counter still follows the pop; the decoder never
// asks for both, and a push is the safer of the two to honour.
//
// Flag contexts
// Only one previous context is remembered. A non-maskable event
// taken inside an interrupt handler returns to the interrupt pair, but
// one more event nested inside it makes that return go to normal mode,
// not to the interrupt pair. The core never nests that way.
// A flag update in the same cycle as a context switch lands in the
// pair that was active before the switch.
//
// Reset
// Reset is synchronous and active high. All registers clear, the
// stack empties and the core starts in non-maskable mode, so the
// start-up code runs on the non-maskable flag pair.

module ccr_core_regs #(
	parameter PC_W = 12,
	parameter DEPTH = `CCR_STACK_DEPTH
) (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// Data-space port
	input wire ds_wr,
	input wire [7:0] ds_addr,
	input wire [7:0] ds_wdata,
	output reg [7:0] ds_rdata,
	output wire ds_hit,
	// Accumulator write from the instruction path
	input wire acc_wr,
	input wire [7:0] acc_wdata,
	// Program counter control
	input wire [2:0] pc_op,
	input wire [PC_W-1:0] pc_target,
	input wire [7:0] pc_offset,
	input wire [PC_W-1:0] pc_vector,
	// Stack and context events
	input wire push_stack,
	input wire irq_take,
	input wire nmi_take,
	input wire return_from_interrupt,
	// Flag update from the ALU
	input wire [1:0] flag_src,
	input wire [7:0] alu_result,
	input wire alu_carry,
	input wire bit_value,
	// Visible state
	output reg [7:0] accumulator,
	output reg [7:0] pointer_reg_one,
	output reg [7:0] pointer_reg_two,
	output reg [7:0] short_direct_first,
	output reg [7:0] short_direct_second,
	output reg [PC_W-1:0] pc_reg,
	output wire carry_flag,
	output wire zero_flag,
	output wire [2:0] context_mode,
	output wire [2:0] stack_level
);

	// ==========================================================
	// Storage
	reg [PC_W-1:0] stack_mem [0:DEPTH-1];
	wire [DEPTH*PC_W-1:0] stack_next_flat;
	wire pop_shift;
	integer k;
	localparam [2:0] DEPTH_TOP = DEPTH;
	reg [2:0] depth_reg;
	reg [2:0] ctx_reg;
	reg [2:0] ctx_prev_reg;
	reg carry_normal;
	reg zero_normal;
	reg carry_irq;
	reg zero_irq;
	reg carry_nonmask;
	reg zero_nonmask;
	reg [PC_W-1:0] pc_next;
	wire do_pop;
	wire do_push;
	wire new_zero;
	wire new_carry;
	wire [PC_W-1:0] offset_ext;

	// ==========================================================
	// Data-space decode
	assign ds_hit = (ds_addr == `CCR_ADDR_ACC) ||
		(ds_addr == `CCR_ADDR_PTR_ONE) || (ds_addr == `CCR_ADDR_PTR_TWO) ||
		(ds_addr == `CCR_ADDR_SD_FIRST) || (ds_addr == `CCR_ADDR_SD_SECOND);

	// Read mux; unmapped addresses return zero
	always @* begin
		case (ds_addr)
			`CCR_ADDR_ACC: ds_rdata = accumulator;
			`CCR_ADDR_PTR_ONE: ds_rdata = pointer_reg_one;
			`CCR_ADDR_PTR_TWO: ds_rdata = pointer_reg_two;
			`CCR_ADDR_SD_FIRST: ds_rdata = short_direct_first;
			`CCR_ADDR_SD_SECOND: ds_rdata = short_direct_second;
			default: ds_rdata = 8'h00;
		endcase
	end

	// Data registers; data-space write wins over the internal path
	// because both come from the same instruction anyway
	always @(posedge mclk) begin
		if (sys_rst) begin
			accumulator <= `CCR_RST_BYTE;
			pointer_reg_one <= `CCR_RST_BYTE;
			pointer_reg_two <= `CCR_RST_BYTE;
			short_direct_first <= `CCR_RST_BYTE;
			short_direct_second <= `CCR_RST_BYTE;
		end else begin
			if (ds_wr && ds_addr == `CCR_ADDR_ACC)
				accumulator <= ds_wdata;
			else if (acc_wr)
				accumulator <= acc_wdata;
			if (ds_wr && ds_addr == `CCR_ADDR_PTR_ONE)
				pointer_reg_one <= ds_wdata;
			if (ds_wr && ds_addr == `CCR_ADDR_PTR_TWO)
				pointer_reg_two <= ds_wdata;
			if (ds_wr && ds_addr == `CCR_ADDR_SD_FIRST)
				short_direct_first <= ds_wdata;
			if (ds_wr && ds_addr == `CCR_ADDR_SD_SECOND)
				short_direct_second <= ds_wdata;
		end
	end

	// ==========================================================
	// Program counter
	assign offset_ext = {{(PC_W-8){pc_offset[7]}}, pc_offset};
	assign do_pop = (pc_op == `CCR_PC_POP);
	assign do_push = push_stack | irq_take | nmi_take;

	// Next PC; an empty-stack return falls through to PC+1
	always @* begin
		case (pc_op)
			`CCR_PC_INC: pc_next = pc_reg + 1'b1;
			`CCR_PC_LOAD: pc_next = pc_target;
			`CCR_PC_REL: pc_next = pc_reg + offset_ext;
			`CCR_PC_VEC: pc_next = pc_vector;
			`CCR_PC_POP: begin
				if (depth_reg != 3'h0)
					pc_next = stack_mem[0];
				else
					pc_next = pc_reg + 1'b1;
			end
			default: pc_next = pc_reg;
		endcase
	end

	// PC register, twelve bits wraps within program space
	always @(posedge mclk) begin
		if (sys_rst)
			pc_reg <= `CCR_RST_PC;
		else
			pc_reg <= pc_next;
	end

	// ==========================================================
	// Return stack: push saves current PC before it moves
	// Empty stack never shifts, so a stray return keeps the levels
	assign pop_shift = do_pop && (depth_reg != 3'h0);

	// Next value of each level; ends tie to the PC and to itself
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_stk
			wire [PC_W-1:0] shallower;
			wire [PC_W-1:0] deeper;
			if (gi == 0) begin : g_top
				assign shallower = pc_reg;
			end else begin : g_mid
				assign shallower = stack_mem[gi-1];
			end
			if (gi == DEPTH-1) begin : g_end
				assign deeper = stack_mem[gi];
			end else begin : g_in
				assign deeper = stack_mem[gi+1];
			end
			assign stack_next_flat[gi*PC_W +: PC_W] = do_push ? shallower :
				pop_shift ? deeper : stack_mem[gi];
		end
	endgenerate

	// One process owns the whole stack, so no level has two drivers
	always @(posedge mclk) begin
		for (k = 0; k < DEPTH; k = k + 1) begin
			if (sys_rst)
				stack_mem[k] <= `CCR_RST_PC;
			else
				stack_mem[k] <= stack_next_flat[k*PC_W +: PC_W];
		end
	end

	// Depth counter saturates at both ends
	always @(posedge mclk) begin
		if (sys_rst)
			depth_reg <= 3'h0;
		else if (do_push && depth_reg != DEPTH_TOP)
			depth_reg <= depth_reg + 3'h1;
		else if (do_pop && !do_push && depth_reg != 3'h0)
			depth_reg <= depth_reg - 3'h1;
	end
	assign stack_level = depth_reg;

	// ==========================================================
	// Context and flag pairs
	// Only one level of previous context is kept; deeper nesting
	// returns to normal mode; a single NMI inside an IRQ still returns to IRQ
	always @(posedge mclk) begin
		if (sys_rst) begin
			ctx_reg <= `CCR_CTX_NMI;
			ctx_prev_reg <= `CCR_CTX_NORMAL;
		end else if (nmi_take) begin
			ctx_prev_reg <= ctx_reg;
			ctx_reg <= `CCR_CTX_NMI;
		end else if (irq_take) begin
			ctx_prev_reg <= ctx_reg;
			ctx_reg <= `CCR_CTX_IRQ;
		end else if (return_from_interrupt) begin
			ctx_reg <= ctx_prev_reg;
			ctx_prev_reg <= `CCR_CTX_NORMAL;
		end
	end
	assign context_mode = ctx_reg;

	assign new_zero = (alu_result == 8'h00);
	assign new_carry = (flag_src == `CCR_FL_BIT) ? bit_value :
		(flag_src == `CCR_FL_ARITH) ? alu_carry : carry_flag;

	// Only the active pair is written; switches never clear flags
	always @(posedge mclk) begin
		if (sys_rst) begin
			carry_normal <= 1'b0;
			zero_normal <= 1'b0;
			carry_irq <= 1'b0;
			zero_irq <= 1'b0;
			carry_nonmask <= 1'b0;
			zero_nonmask <= 1'b0;
		end else if (flag_src != `CCR_FL_NONE) begin
			case (ctx_reg)
				`CCR_CTX_NORMAL: begin
					carry_normal <= new_carry;
					if (flag_src != `CCR_FL_BIT)
						zero_normal <= new_zero;
				end
				`CCR_CTX_IRQ: begin
					carry_irq <= new_carry;
					if (flag_src != `CCR_FL_BIT)
						zero_irq <= new_zero;
				end
				`CCR_CTX_NMI: begin
					carry_nonmask <= new_carry;
					if (flag_src != `CCR_FL_BIT)
						zero_nonmask <= new_zero;
				end
				default: begin
					carry_normal <= carry_normal;
				end
			endcase
		end
	end

	// Active pair out
	assign carry_flag = ctx_reg[2] ? carry_nonmask :
		ctx_reg[1] ? carry_irq : carry_normal;
	assign zero_flag = ctx_reg[2] ? zero_nonmask :
		ctx_reg[1] ? zero_irq : zero_normal;

endmodule
`default_nettype wire

// [design/ccr_map.vh]
`ifndef CCR_MAP_VH
`define CCR_MAP_VH
// Data-space addresses of the core registers
`define CCR_ADDR_PTR_ONE 8'h80
`define CCR_ADDR_PTR_TWO 8'h81
`define CCR_ADDR_SD_FIRST 8'h82
`define CCR_ADDR_SD_SECOND 8'h83
`define CCR_ADDR_ACC 8'hff
// Register reset values
`define CCR_RST_BYTE 8'h00
`define CCR_RST_PC 12'h000
// Flag context codes, one-hot
`define CCR_CTX_NORMAL 3'b001
`define CCR_CTX_IRQ 3'b010
`define CCR_CTX_NMI 3'b100
// Program counter operations
`define CCR_PC_HOLD 3'h0
`define CCR_PC_INC 3'h1
`define CCR_PC_LOAD 3'h2
`define CCR_PC_REL 3'h3
`define CCR_PC_VEC 3'h4
`define CCR_PC_POP 3'h5
// Flag update sources
`define CCR_FL_NONE 2'h0
`define CCR_FL_ARITH 2'h1
`define CCR_FL_LOGIC 2'h2
`define CCR_FL_BIT 2'h3
// Stack depth
`define CCR_STACK_DEPTH 6
`endif

// [verif/ccr_core_regs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker on the core register ports
module ccr_core_regs_checker #(parameter PC_W = 12) (
	// Clock, reset and inputs
	input wire logic mclk, sys_rst, ds_wr, push_stack, irq_take, nmi_take,
	input wire logic return_from_interrupt, alu_carry,
	input wire logic [7:0] ds_addr, ds_wdata, pc_offset, alu_result,
	input wire logic [2:0] pc_op,
	input wire logic [1:0] flag_src,
	// Observed state
	input wire logic [7:0] ds_rdata, accumulator, pointer_reg_two,
	input wire logic [PC_W-1:0] pc_reg,
	input wire logic carry_flag, zero_flag,
	input wire logic [2:0] context_mode, stack_level
);
	// Offset widened here, since a slice of a past value is not portable
	wire logic [PC_W-1:0] off_ext = {{(PC_W-8){pc_offset[7]}}, pc_offset};
	wire logic ev = irq_take | nmi_take | return_from_interrupt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_acc_ds_write: assert property (ds_wr && ds_addr == 8'hff |=>
		accumulator == $past(ds_wdata)) else $error("acc write lost");
	a_ptr_ds_read: assert property (ds_addr == 8'h81 |->
		ds_rdata == pointer_reg_two) else $error("pointer read wrong");
	a_pc_increment: assert property (pc_op == 3'h1 |=>
		pc_reg == $past(pc_reg) + 12'h1) else $error("pc step wrong");
	a_pc_relative: assert property (pc_op == 3'h3 |=>
		pc_reg == $past(pc_reg) + $past(off_ext)) else $error("branch wrong");
	a_irq_context: assert property (irq_take && !nmi_take |=>
		context_mode == 3'b010) else $error("irq context wrong");
	a_reset_nmi: assert property ($fell(sys_rst) |->
		context_mode == 3'b100 && pc_reg == 12'h000) else $error("reset state");
	a_stack_push: assert property (push_stack && stack_level < 3'd6 |=>
		stack_level == $past(stack_level) + 3'd1) else $error("push depth");
	a_empty_pop: assert property (pc_op == 3'h5 && stack_level == 3'd0
		&& !push_stack && !irq_take && !nmi_take |=> stack_level == 3'd0
		&& pc_reg == $past(pc_reg) + 12'h1) else $error("empty pop wrong");
	a_arith_flags: assert property (flag_src == 2'h1 && !ev |=>
		carry_flag == $past(alu_carry)
		&& zero_flag == ($past(alu_result) == 8'h00)) else $error("flags");
endmodule
bind ccr_core_regs ccr_core_regs_checker #(.PC_W(PC_W)) chk (.mclk, .sys_rst,
	.ds_wr, .push_stack, .irq_take, .nmi_take, .return_from_interrupt,
	.alu_carry, .ds_addr, .ds_wdata, .pc_offset, .alu_result, .pc_op,
	.flag_src, .ds_rdata, .accumulator, .pointer_reg_two, .pc_reg,
	.carry_flag, .zero_flag, .context_mode, .stack_level);
`default_nettype wire

// [verif/ccr_decoder_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Decoder and data-space bus model, one request per cycle
module ccr_decoder_model (
	// Clock
	input wire logic mclk,
	// Strobes and operands
	output logic ds_wr, acc_wr, push_stack, irq_take, nmi_take, rfi,
	output logic [2:0] pc_op,
	output logic [1:0] flag_src,
	output logic [7:0] data,
	output logic [11:0] addr,
	output logic carry
);
	// Every field set once at a falling edge, held across the sampling edge
	task op(input logic [2:0] p, input logic [5:0] e, input logic [1:0] f,
		input logic [7:0] d, input logic c, input logic [11:0] a);
		{ds_wr, acc_wr, push_stack, irq_take, nmi_take, rfi} = e;
		pc_op = p;
		flag_src = f;
		data = d;
		carry = c;
		addr = a;
		@(negedge mclk);
	endtask
	initial {ds_wr, acc_wr, push_stack, irq_take, nmi_take, rfi, pc_op,
		flag_src, data, addr, carry} = '0;
endmodule
`default_nettype wire

// [verif/cpu_core_registers_flags_stack_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top
module cpu_core_registers_flags_stack_bench;
	logic mclk = 0, sys_rst = 1;
	int errors = 0, num_checks = 0, i;
	logic [7:0] rd, acc, p1, p2, s1, s2, ad[5];
	logic [11:0] pc;
	logic c, z, hit;
	logic [2:0] ctx, lvl;
	wire logic dw, aw, ps, it, nt, rf, ca;
	wire logic [2:0] po;
	wire logic [1:0] fs;
	wire logic [7:0] d;
	wire logic [11:0] a;
	always #20 mclk = ~mclk;
	ccr_decoder_model m (.mclk(mclk), .ds_wr(dw), .acc_wr(aw), .push_stack(ps),
		.irq_take(it), .nmi_take(nt), .rfi(rf), .pc_op(po), .flag_src(fs),
		.data(d), .addr(a), .carry(ca));
	ccr_core_regs dut (.mclk(mclk), .sys_rst(sys_rst), .ds_wr(dw),
		.ds_addr(a[7:0]), .ds_wdata(d), .ds_rdata(rd), .ds_hit(hit),
		.acc_wr(aw), .acc_wdata(d), .pc_op(po), .pc_target(a), .pc_offset(d),
		.pc_vector(a), .push_stack(ps), .irq_take(it), .nmi_take(nt),
		.return_from_interrupt(rf), .flag_src(fs), .alu_result(d),
		.alu_carry(ca), .bit_value(ca), .accumulator(acc),
		.pointer_reg_one(p1), .pointer_reg_two(p2), .short_direct_first(s1),
		.short_direct_second(s2), .pc_reg(pc), .carry_flag(c), .zero_flag(z),
		.context_mode(ctx), .stack_level(lvl));
	// One compare for every result, wide enough for the counter
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task report_and_stop;
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard, far beyond the fifty or so cycles used
	initial begin
		#100000;
		errors++;
		report_and_stop();
	end
	initial begin
		ad = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
		repeat (12) @(negedge mclk);
		sys_rst = 0;
		chk("ctx", 3'b100, ctx);
		chk("pc", 12'h000, pc);
		// Each mapped register written then read back over data space
		for (i = 0; i < 5; i++) begin
			m.op(0, 6'h20, 0, ad[i] ^ 8'h5a, 0, {4'h0, ad[i]});
			m.op(0, 0, 0, 0, 0, {4'h0, ad[i]});
			chk("rdata", ad[i] ^ 8'h5a, rd);
			chk("hit", 1'b1, hit);
		end
		chk("pointers", 16'hdadb, {p1, p2});
		chk("short direct", 16'hd8d9, {s1, s2});
		m.op(0, 6'h20, 0, 8'h77, 0, 12'h090);
		chk("unmapped", 12'h000, {hit, rd});
		m.op(0, 6'h10, 0, 8'h3c, 0, 0);
		chk("acc", 8'h3c, acc);
		// Program counter sources, wrap at twelve bits
		m.op(2, 0, 0, 0, 0, 12'hfff);
		m.op(1, 0, 0, 0, 0, 0);
		chk("pc wrap", 12'h000, pc);
		m.op(3, 0, 0, 8'hfe, 0, 0);
		chk("pc rel", 12'hffe, pc);
		m.op(4, 0, 0, 0, 0, 12'h123);
		chk("pc vec", 12'h123, pc);
		// Seven calls overflow the stack, oldest return address lost
		for (i = 0; i < 7; i++) m.op(2, 6'h08, 0, 0, 0, 12'h200 + i);
		chk("depth", 3'd6, lvl);
		for (i = 0; i < 6; i++) begin
			m.op(5, 0, 0, 0, 0, 0);
			chk("pop", 12'h205 - i, pc);
		end
		m.op(5, 0, 0, 0, 0, 0);
		chk("empty pop", 12'h201, {lvl, pc});
		// Flag pairs kept apart per context
		m.op(0, 0, 1, 8'h00, 1, 0);
		chk("nmi cz", 2'b11, {c, z});
		m.op(5, 6'h01, 0, 0, 0, 0);
		chk("normal", 5'b00100, {ctx, c, z});
		m.op(0, 0, 2, 8'h00, 1, 0);
		m.op(0, 0, 3, 8'h01, 1, 0);
		chk("bit", 2'b11, {c, z});
		m.op(4, 6'h04, 0, 0, 0, 12'h010);
		chk("irq", 5'b01000, {ctx, c, z});
		m.op(0, 0, 1, 8'h10, 1, 0);
		m.op(5, 6'h01, 0, 0, 0, 0);
		chk("back", 5'b00111, {ctx, c, z});
		m.op(4, 6'h02, 0, 0, 0, 12'h020);
		chk("nmi", 5'b10011, {ctx, c, z});
		report_and_stop();
	end
endmodule
`default_nettype wire
